// ### design/pwm_fault_regs.svh
// Purpose: Constants for the PWM fault/dither block
// Assumes: Included by bare name
// Notes: Mode codes, counter width and reset values
`ifndef PWM_FAULT_REGS_SVH
`define PWM_FAULT_REGS_SVH
`define CNT_W 12
`define DITHER_W 4
`define MODE_W 4
`define MODE_NONE 4'h0
`define MODE_WAIT_OTHER 4'h1
`define MODE_OTHER_WAIT 4'h2
`define MODE_REPEAT_OTHER 4'h3
`define MODE_STOP_ALL 4'h4
`define MODE_DEAD_ONLY 4'h5
`define MODE_HALT_ALL 4'h6
`define MODE_HALT_SW 4'h7
`define MODE_EDGE_JUMP 4'h8
`define MODE_EDGE_BLOCK 4'h9
`define MODE_LEVEL_BLOCK 4'ha
`define RST_LEN 12'h010
`define RST_DITHER 4'h0
`endif

// ### design/pwm_fault_pkg.sv
// Purpose: Types for the PWM fault/dither block
// Assumes: Nothing
// Notes: Phase enumeration of the timer cycle
package pwm_fault_pkg;
    typedef enum logic [1:0] {GAP_A, ON_A, GAP_B, ON_B} phase_t;
endpackage

// ### design/dither_accum.sv
// Purpose: Fractional error accumulator for period dithering
// Assumes: step pulses once per timer cycle
// Notes: extra pulses for one cycle when the sum wraps
`timescale 1ns/1ps
`include "pwm_fault_regs.svh"
module dither_accum #(
    parameter int W = `DITHER_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Control
    input wire logic step,
    input wire logic [W-1:0] frac,
    // Result
    output logic extra
);
    logic [W-1:0] acc;
    wire logic [W:0] sum = {1'b0, acc} + {1'b0, frac};

    initial
    begin
        if (W < 1 || W > 16)
            $error("dither width out of range");
    end

    // Accumulate once per cycle, flag on carry
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            acc <= '0;
            extra <= 1'b0;
        end
        else
        begin
            extra <= step & sum[W];
            if (step)
                acc <= sum[W-1:0];
        end
    end
endmodule

// ### design/pwm_fault_dither.sv
// Purpose: Fault input modes and dither for a two-output PWM timer
// Assumes: Event inputs asynchronous, synchronised here; one clock
// Notes: Cycle is gap A, on A, gap B, on B, each a programmed length
//
// Functional notes
// - Mode 9: rising edge during on-time blanks that output for rest of on-time
// - Mode 9: counter sequence and period unaffected
// - Mode 10: output held off while its input is active, A to A, B to B
// - Mode 10: released mid on-time, output stays off until on-time ends
// - Mode 10: counter sequence unaffected
// - Mode 1: end on-time and wait; on release start other gap
// - Mode 2: end on-time, run other cycle, wait; release restarts current gap
// - Mode 3: finish on-time, repeat other cycle; release re-enables current
// - Mode 6: either input ends both on-times, halts; release starts other gap
// - Mode 7: either input halts until restart; resume at current gap
// - Mode 8: edge ends associated on-time, jump to other gap
// - Dither adds fractional error to accumulator once per timer cycle
// - Accumulator overflow inserts one extra count in selected phase
// - Mode 4: either input blanks both outputs while active; counter unaffected
// - Mode 5: dead-times alternate while active; finish gap after release
`timescale 1ns/1ps
`include "pwm_fault_regs.svh"
module pwm_fault_dither #(
    parameter int CW = `CNT_W,
    parameter int DW = `DITHER_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Event inputs and modes
    input wire logic event_a,
    input wire logic event_b,
    input wire logic [`MODE_W-1:0] fault_mode_code_a,
    input wire logic [`MODE_W-1:0] fault_mode_code_b,
    input wire logic restart,
    // Phase lengths and dither
    input wire logic [CW-1:0] len_gap_a,
    input wire logic [CW-1:0] len_on_a,
    input wire logic [CW-1:0] len_gap_b,
    input wire logic [CW-1:0] len_on_b,
    input wire logic [DW-1:0] dither_frac,
    input wire logic dither_on_b,
    // Outputs
    output logic wave_out_a,
    output logic wave_out_b,
    output pwm_fault_pkg::phase_t phase
);
    import pwm_fault_pkg::*;

    initial
    begin
        if (CW < 2 || CW > 16)
            $error("counter width out of range");
    end

    // Two-stage synchronisers
    logic [1:0] sync_a, sync_b;
    logic ev_a, ev_b, ev_a_d, ev_b_d;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sync_a <= 2'h0;
            sync_b <= 2'h0;
            ev_a_d <= 1'b0;
            ev_b_d <= 1'b0;
        end
        else
        begin
            sync_a <= {sync_a[0], event_a};
            sync_b <= {sync_b[0], event_b};
            ev_a_d <= sync_a[1];
            ev_b_d <= sync_b[1];
        end
    end
    assign ev_a = sync_a[1];
    assign ev_b = sync_b[1];
    wire logic rise_a = ev_a & ~ev_a_d;
    wire logic rise_b = ev_b & ~ev_b_d;

    // Mode decode per input
    function automatic logic hit(input logic [`MODE_W-1:0] m, input logic [`MODE_W-1:0] c);
        hit = (m == c);
    endfunction
    wire logic [`MODE_W-1:0] ma = fault_mode_code_a;
    wire logic [`MODE_W-1:0] mb = fault_mode_code_b;
    // Either-input modes: any input in that mode triggers both outputs
    wire logic all4 = (hit(ma, `MODE_STOP_ALL) & ev_a) | (hit(mb, `MODE_STOP_ALL) & ev_b);
    wire logic all5 = (hit(ma, `MODE_DEAD_ONLY) & ev_a) | (hit(mb, `MODE_DEAD_ONLY) & ev_b);
    wire logic all6 = (hit(ma, `MODE_HALT_ALL) & ev_a) | (hit(mb, `MODE_HALT_ALL) & ev_b);
    wire logic all7 = (hit(ma, `MODE_HALT_SW) & ev_a) | (hit(mb, `MODE_HALT_SW) & ev_b);
    // Per-output fault levels for modes 1..3 and 10, rising edges for modes 8 and 9
    wire logic f1a = hit(ma, `MODE_WAIT_OTHER) & ev_a;
    wire logic f1b = hit(mb, `MODE_WAIT_OTHER) & ev_b;
    wire logic f2a = hit(ma, `MODE_OTHER_WAIT) & ev_a;
    wire logic f2b = hit(mb, `MODE_OTHER_WAIT) & ev_b;
    wire logic f3a = hit(ma, `MODE_REPEAT_OTHER) & ev_a;
    wire logic f3b = hit(mb, `MODE_REPEAT_OTHER) & ev_b;
    wire logic e8a = hit(ma, `MODE_EDGE_JUMP) & rise_a;
    wire logic e8b = hit(mb, `MODE_EDGE_JUMP) & rise_b;
    wire logic e9a = hit(ma, `MODE_EDGE_BLOCK) & rise_a;
    wire logic e9b = hit(mb, `MODE_EDGE_BLOCK) & rise_b;
    wire logic l10a = hit(ma, `MODE_LEVEL_BLOCK) & ev_a;
    wire logic l10b = hit(mb, `MODE_LEVEL_BLOCK) & ev_b;

    // Counter state
    phase_t next_phase;
    logic [CW-1:0] cnt;
    logic halt_sw;        // Mode 7 latch, cleared by restart
    logic blank_a, blank_b; // Rest-of-on-time blanking
    logic pend_b, pend_a;   // Mode 2 wait after other cycle

    wire logic [CW-1:0] cur_len = (phase == GAP_A) ? len_gap_a :
                                  (phase == ON_A) ? len_on_a :
                                  (phase == GAP_B) ? len_gap_b : len_on_b;
    wire logic extra;
    logic stretch;
    wire logic in_on_a = (phase == ON_A);
    wire logic in_on_b = (phase == ON_B);
    wire logic stretch_ph = dither_on_b ? in_on_b : (phase == GAP_B);
    // Stretch holds off the end only in the selected phase, else the cycle locks up
    wire logic at_end = (cnt >= cur_len) & ~(stretch & stretch_ph);
    wire logic cyc_end = at_end & in_on_b;

    // Waiting: counter stalls (modes 1, 2, 6, 7)
    // Mode 2 waits at its own gap only after the other cycle has run
    wire logic wait_a = (f1a & (phase == GAP_B)) | (pend_a & f2a & (phase == GAP_A));
    wire logic wait_b = (f1b & (phase == GAP_A)) | (pend_b & f2b & (phase == GAP_B));
    wire logic stall = wait_a | wait_b | all6 | all7 | halt_sw;

    // Next phase: jumps end on-times early, else natural advance
    always_comb
    begin
        next_phase = phase;
        if ((all6 | all7) & (in_on_a | in_on_b))
            next_phase = in_on_a ? GAP_B : GAP_A;
        else if (((f1a | f2a | e8a) & in_on_a) | (all5 & in_on_a))
            next_phase = GAP_B;
        else if (((f1b | f2b | e8b) & in_on_b) | (all5 & in_on_b))
            next_phase = GAP_A;
        else if (stall)
            next_phase = phase;
        else if (at_end)
        begin
            case (phase)
                GAP_A: next_phase = (all5 | f3a) ? GAP_B : ON_A;
                ON_A: next_phase = GAP_B;
                GAP_B: next_phase = (all5 | f3b) ? GAP_A : ON_B;
                ON_B: next_phase = GAP_A;
                default: next_phase = GAP_A;
            endcase
        end
    end

    wire logic moved = (next_phase != phase);

    dither_accum #(.W(DW)) u_dither (
        .mclk(mclk),
        .rst(rst),
        .step(cyc_end & ~stall),
        .frac(dither_frac),
        .extra(extra)
    );

    // Sequencer registers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            phase <= GAP_A;
            cnt <= '0;
            halt_sw <= 1'b0;
            pend_a <= 1'b0;
            pend_b <= 1'b0;
            stretch <= 1'b0;
        end
        else
        begin
            phase <= next_phase;
            if (moved)
                cnt <= '0;
            else if (!stall)
                cnt <= cnt + 1'b1;
            if (restart)
                halt_sw <= 1'b0;
            else if (all7)
                halt_sw <= 1'b1;
            // Mode 2: after the other cycle, wait at current gap
            if (f2a & in_on_a & moved)
                pend_a <= 1'b1;
            else if (~f2a)
                pend_a <= 1'b0;
            if (f2b & in_on_b & moved)
                pend_b <= 1'b1;
            else if (~f2b)
                pend_b <= 1'b0;
            // One extra count in the selected phase after overflow
            if (extra)
                stretch <= 1'b1;
            else if (stretch & stretch_ph & (cnt >= cur_len))
                stretch <= 1'b0;
        end
    end

    // Output blanking, held to end of on-time; gating follows the phase being entered
    wire logic hold_a = (e9a & in_on_a) | l10a;
    wire logic hold_b = (e9b & in_on_b) | l10b;
    wire logic enter_on_a = (next_phase == ON_A);
    wire logic enter_on_b = (next_phase == ON_B);
    // Modes 1, 2, 4 and 5 keep the on-time dark from its first cycle
    wire logic cut_a = f1a | f2a | all4 | all5;
    wire logic cut_b = f1b | f2b | all4 | all5;
    wire logic next_wave_a = enter_on_a & ~blank_a & ~hold_a & ~cut_a;
    wire logic next_wave_b = enter_on_b & ~blank_b & ~hold_b & ~cut_b;

    // Blanks clear only when the on-time ends; counter is untouched
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            blank_a <= 1'b0;
            blank_b <= 1'b0;
            wave_out_a <= 1'b0;
            wave_out_b <= 1'b0;
        end
        else
        begin
            if (!enter_on_a)
                blank_a <= 1'b0;
            else if (hold_a)
                blank_a <= 1'b1;
            if (!enter_on_b)
                blank_b <= 1'b0;
            else if (hold_b)
                blank_b <= 1'b1;
            wave_out_a <= next_wave_a;
            wave_out_b <= next_wave_b;
        end
    end
    // Codes 0 and 11..15 decode to nothing above, so take no action
endmodule

// ### verification/pwm_fault_dither_assertions.sv
// Purpose: Assertions on the ports of the PWM fault/dither block
// Assumes: Mode codes change only while reset is high
// Notes: Bound to the top module below
`timescale 1ns/1ps
`include "pwm_fault_regs.svh"
module pwm_fault_dither_assertions #(
    parameter int CW = 12
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Events and controls
    input wire logic event_a,
    input wire logic event_b,
    input wire logic [`MODE_W-1:0] fault_mode_code_a,
    input wire logic [`MODE_W-1:0] fault_mode_code_b,
    input wire logic [CW-1:0] len_on_a,
    // Outputs
    input wire logic wave_out_a,
    input wire logic wave_out_b,
    input wire pwm_fault_pkg::phase_t phase
);
    import pwm_fault_pkg::*;
    logic [CW-1:0] dwell;
    phase_t prev;
    // Modes that must leave the counter alone
    wire quiet = (fault_mode_code_a inside {4'h0, 4'h4, 4'h9, 4'ha})
        && (fault_mode_code_b inside {4'h0, 4'h4, 4'h9, 4'ha});
    // Cycles spent in the current phase
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            prev <= GAP_A;
            dwell <= '0;
        end
        else
        begin
            prev <= phase;
            dwell <= (phase != prev) ? CW'(1) : dwell + 1'b1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence held_a;
        event_a [*5];
    endsequence
    sequence held_b;
        event_b [*5];
    endsequence
    AST_A_IN_ON: assert property (wave_out_a |-> phase == ON_A)
        else $error("wave_out_a high outside on-time A");
    AST_B_IN_ON: assert property (wave_out_b |-> phase == ON_B)
        else $error("wave_out_b high outside on-time B");
    AST_LVL: assert property (fault_mode_code_a == 4'ha ##0 held_a |-> !wave_out_a)
        else $error("level event did not blank wave_out_a");
    AST_HOLD: assert property (fault_mode_code_a inside {4'h9, 4'ha} && phase == ON_A
        && $past(phase) == ON_A && !$past(wave_out_a) |-> !wave_out_a)
        else $error("wave_out_a came back inside a blanked on-time");
    AST_STOP: assert property (fault_mode_code_a == 4'h4 ##0 held_a
        |-> !wave_out_a && !wave_out_b)
        else $error("outputs active while stop event held");
    AST_HALT: assert property (fault_mode_code_b == 4'h6 ##0 held_b
        |-> !wave_out_a && !wave_out_b)
        else $error("outputs active while halt event held");
    AST_WAIT: assert property (fault_mode_code_a == 4'h1 ##0 held_a |-> !wave_out_a)
        else $error("wave_out_a active while fault held");
    AST_NONE: assert property (fault_mode_code_a == 4'h0 && fault_mode_code_b == 4'h0
        && phase == ON_A && $past(phase) == ON_A |-> wave_out_a)
        else $error("wave_out_a low in on-time with no mode");
    AST_JUMP: assert property (fault_mode_code_a == 4'h8 && phase == ON_A && $rose(event_a)
        |-> ##[1:5] phase == GAP_B)
        else $error("edge in on-time A did not reach gap B");
    AST_ON_LEN: assert property (quiet && $past(phase) == ON_A && phase != ON_A
        |-> $past(dwell) == len_on_a)
        else $error("on-time A length changed");
endmodule
bind pwm_fault_dither pwm_fault_dither_assertions #(.CW(CW)) chk_u (.mclk(mclk),
    .rst(rst), .event_a(event_a), .event_b(event_b), .fault_mode_code_a(fault_mode_code_a),
    .fault_mode_code_b(fault_mode_code_b), .len_on_a(len_on_a), .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b), .phase(phase));

// ### verification/event_source.sv
// Purpose: Event routing model feeding the two event inputs
// Assumes: Bench requests change on the falling edge
// Notes: Lines follow requests one falling edge later
`timescale 1ns/1ps
module event_source (
    // Clock
    input wire logic mclk,
    // Requests
    input wire logic want_a,
    input wire logic want_b,
    // Event lines
    output logic event_a,
    output logic event_b
);
    // Idle low from time zero
    initial
    begin
        event_a = 1'b0;
        event_b = 1'b0;
    end
    // Levels move away from the sampling edge
    always @(negedge mclk)
    begin
        event_a <= want_a;
        event_b <= want_b;
    end
endmodule

// ### verification/pwm_fault_dither_tb.sv
// Purpose: Self-checking bench for the PWM fault/dither block
// Assumes: Phase lengths 3,4,3,4 cycles
// Notes: Each scenario resets the block first
`timescale 1ns/1ps
module pwm_fault_dither_tb;
    import pwm_fault_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic want_a = 1'b0;
    logic want_b = 1'b0;
    logic restart = 1'b0;
    logic dither_on_b = 1'b0;
    logic [3:0] dither_frac = 4'h0;
    logic [3:0] code_a = 4'h0;
    logic [3:0] code_b = 4'h0;
    logic event_a;
    logic event_b;
    logic wave_out_a;
    logic wave_out_b;
    phase_t phase;
    int bad_count = 0;
    int tests_run = 0;
    // Clock
    always #20 mclk = ~mclk;
    // Block and event model
    pwm_fault_dither dut_u (.mclk(mclk), .rst(rst), .event_a(event_a), .event_b(event_b),
        .fault_mode_code_a(code_a), .fault_mode_code_b(code_b), .restart(restart),
        .len_gap_a(12'h002), .len_on_a(12'h003), .len_gap_b(12'h002), .len_on_b(12'h003),
        .dither_frac(dither_frac), .dither_on_b(dither_on_b), .wave_out_a(wave_out_a),
        .wave_out_b(wave_out_b), .phase(phase));
    event_source src_u (.mclk(mclk), .want_a(want_a), .want_b(want_b), .event_a(event_a),
        .event_b(event_b));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic wrap_up;
        if (bad_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Wait for a fresh entry into phase p
    task automatic enter(input phase_t p);
        int n;
        for (n = 0; n < 60 && phase === p; n++) @(negedge mclk);
        for (n = n; n < 60 && phase !== p; n++) @(negedge mclk);
        chk("phase reached", 16'h1, 16'(n < 60));
    endtask
    // Count high cycles of one output until the phase changes
    task automatic highs(input bit sel_b, output int c);
        phase_t p;
        p = phase;
        c = 0;
        while (phase === p)
        begin
            c += ((sel_b ? wave_out_b : wave_out_a) === 1'b1);
            @(negedge mclk);
        end
    endtask
    task automatic start(input logic [3:0] a, input logic [3:0] b);
        @(negedge mclk);
        rst = 1'b1;
        code_a = a;
        code_b = b;
        dither_frac = 4'h0;
        want_a <= 1'b0;
        want_b <= 1'b0;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
    endtask
    task automatic t_dither(input logic sel, input logic [3:0] f);
        time t0;
        start(4'h0, 4'h0);
        dither_on_b = sel;
        dither_frac = f;
        enter(ON_A);
        t0 = $time;
        repeat (16) enter(ON_A);
        chk("sixteen periods", 16'(224 + (15 * f) / 16), 16'(($time - t0) / 40));
    endtask
    task automatic t_level;
        int c;
        start(4'ha, 4'ha);
        enter(GAP_B);
        want_a <= 1'b1;
        enter(ON_B);
        highs(1'b1, c);
        chk("other output", 16'h4, 16'(c));
        repeat (2) @(negedge mclk);
        want_a <= 1'b0;
        enter(ON_A);
        highs(1'b0, c);
        chk("released mid on-time", 16'h0, 16'(c));
        enter(ON_A);
        highs(1'b0, c);
        chk("next on-time", 16'h4, 16'(c));
    endtask
    task automatic t_edge9;
        int c;
        start(4'h9, 4'h0);
        enter(GAP_B);
        want_a <= 1'b1;
        enter(ON_A);
        highs(1'b0, c);
        chk("edge outside on-time", 16'h4, 16'(c));
        want_a <= 1'b0;
        enter(GAP_A);
        repeat (2) @(negedge mclk);
        want_a <= 1'b1;
        enter(ON_A);
        highs(1'b0, c);
        chk("edge blanks on-time", 16'h1, 16'(c < 4));
        enter(ON_A);
        highs(1'b0, c);
        chk("one edge acts once", 16'h4, 16'(c));
    endtask
    task automatic t_jump8;
        int c;
        start(4'h8, 4'h0);
        enter(GAP_A);
        repeat (2) @(negedge mclk);
        want_a <= 1'b1;
        enter(ON_A);
        highs(1'b0, c);
        chk("on-time cut short", 16'h1, 16'(c < 4));
        chk("jump target", 16'(GAP_B), 16'(phase));
    endtask
    task automatic t_hold(input logic [3:0] m, input bit sw);
        phase_t p;
        start(m, m);
        enter(ON_A);
        want_b <= 1'b1;
        if (sw)
        begin
            repeat (6) @(negedge mclk);
            want_b <= 1'b0;
        end
        repeat (20) @(negedge mclk);
        p = phase;
        repeat (10) @(negedge mclk);
        chk("counter held", 16'(p), 16'(phase));
        chk("outputs off", 16'h0, {14'h0, wave_out_a, wave_out_b});
        want_b <= 1'b0;
        restart = sw;
        @(negedge mclk);
        restart = 1'b0;
        enter(ON_A);
    endtask
    task automatic t_modes;
        logic [3:0] m[6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hb};
        int c;
        foreach (m[i])
        begin
            start(m[i], m[i]);
            enter(GAP_B);
            want_a <= 1'b1;
            repeat (6) @(negedge mclk);
            c = 0;
            repeat (20)
            begin
                @(negedge mclk);
                c += (wave_out_a === 1'b1);
            end
            chk("output while held", 16'(m[i] == 4'hb), 16'(c > 0));
            want_a <= 1'b0;
            enter(ON_A);
            enter(ON_A);
            highs(1'b0, c);
            chk("resumed on-time", 16'h4, 16'(c));
        end
    endtask
    // Main sequence
    initial
    begin
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        t_dither(1'b1, 4'h5);
        t_dither(1'b0, 4'hf);
        t_level;
        t_edge9;
        t_jump8;
        t_hold(4'h6, 1'b0);
        t_hold(4'h7, 1'b1);
        t_modes;
        wrap_up;
    end
    // Watchdog
    initial
    begin
        #800000;
        bad_count++;
        wrap_up;
    end
endmodule
